// ### pio_pkg.sv
// =====================================================================
// parallel port constants and types
// =====================================================================
package pio_pkg;

    // port slots: each slot is one separately addressed byte or word
    localparam int            NSLOT      = 11;
    localparam int            SLOT_W     = 16;
    localparam int            NPIN       = NSLOT * SLOT_W;
    localparam logic [3:0]    SLOT_P0L   = 4'h0;
    localparam logic [3:0]    SLOT_P0H   = 4'h1;
    localparam logic [3:0]    SLOT_P1L   = 4'h2;
    localparam logic [3:0]    SLOT_P1H   = 4'h3;
    localparam logic [3:0]    SLOT_P2    = 4'h4;
    localparam logic [3:0]    SLOT_P3    = 4'h5;
    localparam logic [3:0]    SLOT_P4    = 4'h6;
    localparam logic [3:0]    SLOT_P5    = 4'h7;
    localparam logic [3:0]    SLOT_P6    = 4'h8;
    localparam logic [3:0]    SLOT_P7    = 4'h9;
    localparam logic [3:0]    SLOT_P8    = 4'hA;
    localparam logic [3:0]    SLOT_THR   = 4'hB;

    // byte offset = slot * 0x20 + register * 4
    localparam int            ADDR_SLOT_LSB = 5;
    localparam int            ADDR_REG_LSB  = 2;
    localparam logic [2:0]    REG_DATA   = 3'h0;
    localparam logic [2:0]    REG_DIR    = 3'h1;
    localparam logic [2:0]    REG_OD     = 3'h2;
    localparam logic [2:0]    REG_RMW    = 3'h3;
    localparam logic [2:0]    REG_THR    = 3'h0;
    localparam logic [2:0]    REG_XTHR   = 3'h1;

    // line masks
    localparam logic [15:0]   MASK_BYTE  = 16'h00FF;
    localparam logic [15:0]   MASK_WORD  = 16'hFFFF;
    localparam logic [15:0]   MASK_P3    = 16'hBFFF;
    localparam int            P3_GAP_BIT = 14;

    // threshold select field positions
    localparam int            THR_P0L    = 0;
    localparam int            THR_P0H    = 1;
    localparam int            THR_P1L    = 2;
    localparam int            THR_P1H    = 3;
    localparam int            THR_P2     = 4;
    localparam int            THR_P3     = 6;
    localparam int            XTHR_P4    = 0;
    localparam int            XTHR_P5    = 1;
    localparam int            XTHR_P7    = 3;
    localparam int            XTHR_P8    = 4;

    // reset values
    localparam logic [15:0]   LATCH_RST  = 16'h0000;
    localparam logic [15:0]   DIR_RST    = 16'h0000;
    localparam logic [15:0]   OD_RST     = 16'h0000;
    localparam logic [7:0]    THR_RST    = 8'h00;
    localparam logic [4:0]    XTHR_RST   = 5'h00;

    typedef struct packed {
        logic [3:0] slot;
        logic [2:0] regsel;
    } pio_addr_t;

    typedef enum logic [1:0] {
        PIO_ST_IDLE   = 2'b01,
        PIO_ST_RDWAIT = 2'b10
    } pio_bus_st_t;

    // implemented lines of a slot
    function automatic logic [15:0] pio_line_mask(input logic [3:0] s);
        case (s)
            SLOT_P2, SLOT_P5: pio_line_mask = MASK_WORD;
            SLOT_P3:          pio_line_mask = MASK_P3;
            default:          pio_line_mask = (s < SLOT_THR) ? MASK_BYTE : 16'h0000;
        endcase
    endfunction

    // lines that can drive; the analog/input port has no driver
    function automatic logic [15:0] pio_out_mask(input logic [3:0] s);
        pio_out_mask = (s == SLOT_P5) ? 16'h0000 : pio_line_mask(s);
    endfunction

    // slots with open-drain choice
    function automatic logic pio_has_od(input logic [3:0] s);
        case (s)
            SLOT_P2, SLOT_P3, SLOT_P4, SLOT_P6, SLOT_P7, SLOT_P8: pio_has_od = 1'b1;
            default: pio_has_od = 1'b0;
        endcase
    endfunction

endpackage

// ### pio_sync.sv
`timescale 1ns/1ps
// =====================================================================
// two-stage pin synchroniser
// =====================================================================
module pio_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // first stage feeds only the second
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;
endmodule

// ### pio_port_top.sv
`timescale 1ns/1ps
// =====================================================================
// parallel port block with ahb-lite register access
// =====================================================================
// Function
// - every pin is sampled into its input latch each clock, input or output
// - input pin: write loads output latch only; read returns sampled pin
// - input pin: read-modify-write takes sampled pin level as source
// - direction 1 enables driver; write sets latch and pin; read gives latch
// - output pin: read-modify-write takes output latch as source
// - ports 2,3,4,6,7,8 choose push-pull or open-drain per bit
// - threshold select per byte: one bit per byte port and for port 5, two for ports 2,3
// - direction and drive mode work regardless of chosen threshold
// - alternate output drives pin only when direction is output
// - alternate pin value is latch AND alternate data, except pwm outputs and bus-mode pins (plain alternate data)
// - all directions reset to input
// - output-direction pin feeds its latch value to the alternate input
// - bus-mode pins get direction switched by hardware while enabled
// - port 3 has fifteen lines, line fourteen absent
// - port 5 is sixteen input-only lines
// - ports 0 and 1 are two separately addressed byte halves each
// - ports 2,4,6,7,8 give 16,8,8,8,8 bidirectional lines
module pio_port_top #(
    parameter int                       PIN_W    = 16,
    parameter logic [pio_pkg::NPIN-1:0] PWM_MASK = '0
) (
    input  wire logic                       clk_i,
    input  wire logic                       nrst_i,
    input  wire logic                       hsel_i,
    input  wire logic [31:0]                haddr_i,
    input  wire logic [1:0]                 htrans_i,
    input  wire logic                       hwrite_i,
    input  wire logic [2:0]                 hsize_i,
    input  wire logic [31:0]                hwdata_i,
    input  wire logic                       hready_i,
    output logic      [31:0]                hrdata_o,
    output logic                            hreadyout_o,
    output logic                            hresp_o,
    input  wire logic [pio_pkg::NPIN-1:0]   pin_in_i,
    input  wire logic [pio_pkg::NPIN-1:0]   alt_out_i,
    input  wire logic [pio_pkg::NPIN-1:0]   alt_en_i,
    input  wire logic [pio_pkg::NPIN-1:0]   hw_dir_en_i,
    input  wire logic [pio_pkg::NPIN-1:0]   hw_dir_i,
    output logic      [pio_pkg::NPIN-1:0]   pin_out_o,
    output logic      [pio_pkg::NPIN-1:0]   pin_oe_o,
    output logic      [pio_pkg::NPIN-1:0]   alt_in_o,
    output logic      [7:0]                 thr_int_o,
    output logic      [4:0]                 thr_ext_o
);
    localparam int NS = pio_pkg::NSLOT;
    localparam int NP = pio_pkg::NPIN;

    // =================================================================
    // elaboration checks
    // =================================================================
    if (PIN_W != pio_pkg::SLOT_W) begin : g_chk
        $error("pio_port_top: PIN_W must equal the slot width");
    end

    // =================================================================
    // state
    // =================================================================
    pio_pkg::pio_bus_st_t st_reg;
    pio_pkg::pio_addr_t   addr_reg;
    logic                 wr_reg;
    logic                 hready_reg;
    logic [31:0]          hrdata_reg;
    logic [15:0]          latch_reg [NS];
    logic [15:0]          dir_reg   [NS];
    logic [15:0]          od_reg    [NS];
    logic [7:0]           thr_reg;
    logic [4:0]           xthr_reg;
    logic [NP-1:0]        pin_out_reg;
    logic [NP-1:0]        pin_oe_reg;
    logic [NP-1:0]        alt_in_reg;

    logic [NP-1:0]        smp;
    logic [NP-1:0]        dir_eff;
    logic [NP-1:0]        drv_val;
    logic [NP-1:0]        od_flat;
    logic [NP-1:0]        view_flat;
    logic [NP-1:0]        alt_in_next;
    logic [31:0]          rd_next;
    logic                 accept;

    function automatic pio_pkg::pio_addr_t pio_dec(input logic [31:0] a);
        pio_dec.slot   = a[pio_pkg::ADDR_SLOT_LSB +: 4];
        pio_dec.regsel = a[pio_pkg::ADDR_REG_LSB +: 3];
    endfunction

    // =================================================================
    // pin sampling
    // =================================================================
    // pins are asynchronous, so the sample is two flops deep
    pio_sync #(
        .W    (NP)
    ) u_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (pin_in_i),
        .q_o    (smp)
    );

    // =================================================================
    // per-line datapath
    // =================================================================
    for (genvar s = 0; s < NS; s++) begin : g_slot
        localparam logic [15:0] LM = pio_pkg::pio_line_mask(4'(s));
        localparam logic [15:0] OM = pio_pkg::pio_out_mask(4'(s));
        for (genvar b = 0; b < 16; b++) begin : g_bit
            localparam int K = s * 16 + b;
            // hardware owns direction of bus-mode lines
            assign dir_eff[K] = (hw_dir_en_i[K] ? hw_dir_i[K] : dir_reg[s][b]) & OM[b];
            // alternate data ANDed with latch unless pwm line or bus-mode line
            assign drv_val[K] = hw_dir_en_i[K] ? alt_out_i[K] :
                                alt_en_i[K] ? (PWM_MASK[K] ? alt_out_i[K]
                                               : (latch_reg[s][b] & alt_out_i[K]))
                                : latch_reg[s][b];
            assign od_flat[K]    = od_reg[s][b];
            // output line reads latch, input line reads pin
            assign view_flat[K]  = (dir_eff[K] ? latch_reg[s][b] : smp[K]) & LM[b];
            // self-trigger path: output line loops latch to the alternate input
            assign alt_in_next[K] = (dir_eff[K] ? latch_reg[s][b] : smp[K]) & LM[b];
        end
    end

    // =================================================================
    // ahb-lite slave control
    // =================================================================
    assign accept = hsel_i & htrans_i[1] & hready_i;

    // reads take one wait state so a write just before is seen
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg     <= pio_pkg::PIO_ST_IDLE;
            hready_reg <= 1'b1;
            wr_reg     <= 1'b0;
            addr_reg   <= '0;
        end else begin
            case (st_reg)
                pio_pkg::PIO_ST_IDLE: begin
                    wr_reg <= accept & hwrite_i;
                    if (accept) begin
                        addr_reg <= pio_dec(haddr_i);
                    end
                    if (accept && !hwrite_i) begin
                        st_reg     <= pio_pkg::PIO_ST_RDWAIT;
                        hready_reg <= 1'b0;
                    end
                end
                pio_pkg::PIO_ST_RDWAIT: begin
                    wr_reg     <= 1'b0;
                    st_reg     <= pio_pkg::PIO_ST_IDLE;
                    hready_reg <= 1'b1;
                end
                default: begin
                    wr_reg     <= 1'b0;
                    st_reg     <= pio_pkg::PIO_ST_IDLE;
                    hready_reg <= 1'b1;
                end
            endcase
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_next = 32'h0000_0000;
        if (addr_reg.slot == pio_pkg::SLOT_THR) begin
            if (addr_reg.regsel == pio_pkg::REG_THR) begin
                rd_next = {24'h00_0000, thr_reg};
            end else if (addr_reg.regsel == pio_pkg::REG_XTHR) begin
                rd_next = {27'h000_0000, xthr_reg};
            end
        end else if (addr_reg.slot < pio_pkg::SLOT_THR) begin
            case (addr_reg.regsel)
                pio_pkg::REG_DATA: rd_next = {16'h0000, view_flat[int'(addr_reg.slot) * 16 +: 16]};
                pio_pkg::REG_DIR:  rd_next = {16'h0000, dir_reg[addr_reg.slot]};
                pio_pkg::REG_OD:   rd_next = {16'h0000, od_reg[addr_reg.slot]};
                default:           rd_next = 32'h0000_0000;
            endcase
        end
    end

    // read data captured at the end of the wait state
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (st_reg == pio_pkg::PIO_ST_RDWAIT) begin
            hrdata_reg <= rd_next;
        end
    end

    // =================================================================
    // port registers
    // =================================================================
    // output latch: plain write or hardware read-modify-write
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int s = 0; s < NS; s++) begin
                latch_reg[s] <= pio_pkg::LATCH_RST;
            end
        end else if (wr_reg) begin
            for (int s = 0; s < NS; s++) begin
                if (addr_reg.slot == 4'(s)) begin
                    if (addr_reg.regsel == pio_pkg::REG_DATA) begin
                        latch_reg[s] <= hwdata_i[15:0] & pio_pkg::pio_out_mask(4'(s));
                    end else if (addr_reg.regsel == pio_pkg::REG_RMW) begin
                        // source is pin for inputs, latch for outputs
                        latch_reg[s] <= ((view_flat[s * 16 +: 16] & ~hwdata_i[31:16])
                                         | (hwdata_i[15:0] & hwdata_i[31:16]))
                                        & pio_pkg::pio_out_mask(4'(s));
                    end
                end
            end
        end
    end

    // direction: input after reset, no driver on input-only port
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int s = 0; s < NS; s++) begin
                dir_reg[s] <= pio_pkg::DIR_RST;
            end
        end else if (wr_reg && addr_reg.regsel == pio_pkg::REG_DIR) begin
            for (int s = 0; s < NS; s++) begin
                if (addr_reg.slot == 4'(s)) begin
                    dir_reg[s] <= hwdata_i[15:0] & pio_pkg::pio_out_mask(4'(s));
                end
            end
        end
    end

    // open-drain select only on ports that have it
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int s = 0; s < NS; s++) begin
                od_reg[s] <= pio_pkg::OD_RST;
            end
        end else if (wr_reg && addr_reg.regsel == pio_pkg::REG_OD) begin
            for (int s = 0; s < NS; s++) begin
                if (addr_reg.slot == 4'(s) && pio_pkg::pio_has_od(4'(s))) begin
                    od_reg[s] <= hwdata_i[15:0] & pio_pkg::pio_out_mask(4'(s));
                end
            end
        end
    end

    // threshold selects only reach the pad comparators and the read mux
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            thr_reg  <= pio_pkg::THR_RST;
            xthr_reg <= pio_pkg::XTHR_RST;
        end else if (wr_reg && addr_reg.slot == pio_pkg::SLOT_THR) begin
            if (addr_reg.regsel == pio_pkg::REG_THR) begin
                thr_reg <= hwdata_i[7:0];
            end else if (addr_reg.regsel == pio_pkg::REG_XTHR) begin
                xthr_reg <= hwdata_i[4:0];
            end
        end
    end

    // =================================================================
    // pin drivers
    // =================================================================
    // open drain only pulls low; driver enabled only for output direction
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_out_reg <= '0;
            pin_oe_reg  <= '0;
            alt_in_reg  <= '0;
        end else begin
            pin_oe_reg  <= dir_eff & (~od_flat | ~drv_val);
            pin_out_reg <= drv_val & ~od_flat;
            alt_in_reg  <= alt_in_next;
        end
    end

    assign hrdata_o    = hrdata_reg;
    assign hreadyout_o = hready_reg;
    assign hresp_o     = 1'b0;
    assign pin_out_o   = pin_out_reg;
    assign pin_oe_o    = pin_oe_reg;
    assign alt_in_o    = alt_in_reg;
    assign thr_int_o   = thr_reg;
    assign thr_ext_o   = xthr_reg;

    // =================================================================
    // assertions
    // =================================================================
    localparam int P2B = 4 * 16;
    localparam int P3B = 5 * 16;
    localparam int P5B = 7 * 16;
    localparam int P4B = 6 * 16;

    AST_SAMPLE_EACH_CLOCK: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $past(nrst_i, 3) |-> smp == $past(pin_in_i, 2))
        else $error("pin sample not two clocks behind the pin");
    AST_OE_NEEDS_DIR: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (pin_oe_o & ~$past(dir_eff)) == '0)
        else $error("pin driven without output direction");
    AST_P5_NO_DRIVER: assert property (@(posedge clk_i) disable iff (!nrst_i)
        pin_oe_o[P5B +: 16] == 16'h0000 && dir_reg[pio_pkg::SLOT_P5] == 16'h0000)
        else $error("input-only port drives");
    AST_P3_GAP: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !pin_oe_o[P3B + pio_pkg::P3_GAP_BIT] && !latch_reg[pio_pkg::SLOT_P3][pio_pkg::P3_GAP_BIT])
        else $error("absent port 3 line is active");
    AST_DATA_WRITE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (wr_reg && addr_reg.slot == pio_pkg::SLOT_P2 && addr_reg.regsel == pio_pkg::REG_DATA)
        |=> latch_reg[pio_pkg::SLOT_P2] == $past(hwdata_i[15:0]))
        else $error("port 2 latch missed a write");
    AST_RMW_SOURCE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (wr_reg && addr_reg.slot == pio_pkg::SLOT_P2 && addr_reg.regsel == pio_pkg::REG_RMW)
        |=> latch_reg[pio_pkg::SLOT_P2] ==
            (($past(view_flat[P2B +: 16]) & ~$past(hwdata_i[31:16]))
             | ($past(hwdata_i[15:0]) & $past(hwdata_i[31:16]))))
        else $error("read-modify-write used the wrong source");

    AST_READ_WAIT: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (accept && !hwrite_i && hready_reg) |=> !hreadyout_o ##1 hreadyout_o)
        else $error("read did not take exactly one wait state");

    AST_ALT_AND: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ($past(alt_en_i[P4B + 4]) && !PWM_MASK[P4B + 4] && !$past(hw_dir_en_i[P4B + 4])
         && !$past(latch_reg[pio_pkg::SLOT_P4][4])) |-> !pin_out_o[P4B + 4])
        else $error("alternate output not gated by latch");

    AST_ALT_IN_LOOP: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $past(dir_eff[P2B]) |-> alt_in_o[P2B] == $past(latch_reg[pio_pkg::SLOT_P2][0]))
        else $error("alternate input not fed from latch");

    AST_THR_WRITE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (wr_reg && addr_reg.slot == pio_pkg::SLOT_THR && addr_reg.regsel == pio_pkg::REG_THR)
        |=> thr_int_o == $past(hwdata_i[7:0]))
        else $error("threshold select missed a write");
endmodule

// ### pio_pin_model.sv
`timescale 1ns/1ps
// =====================================================
// pin side: board drivers with a pull-up on every line
// =====================================================
module pio_pin_model (
    input  wire logic [pio_pkg::NPIN-1:0] pin_out_i,
    input  wire logic [pio_pkg::NPIN-1:0] pin_oe_i,
    input  wire logic [pio_pkg::NPIN-1:0] ext_val_i,
    input  wire logic [pio_pkg::NPIN-1:0] ext_en_i,
    output logic      [pio_pkg::NPIN-1:0] pin_o
);
    // device drive wins; undriven lines float up, so open drain reads 1
    always_comb begin
        pin_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_en_i & ext_val_i)
              | (~pin_oe_i & ~ext_en_i);
    end
endmodule

// ### testbench.sv
`timescale 1ns/1ps
`define CHK(a,b) total_checks++; if ((a)!==(b)) begin n_fail++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end
// =====================================================
// port block bench
// =====================================================
module testbench;
    localparam int B1L = 32, B2 = 64, B3 = 80, B4 = 96, B5 = 112;
    logic        clk_i = 1'b0, nrst_i = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic        hready, hresp;
    logic [pio_pkg::NPIN-1:0] pin, p_out, p_oe, alt_in;
    logic [pio_pkg::NPIN-1:0] alt_out = '0, alt_en = '0, hw_en = '0;
    logic [pio_pkg::NPIN-1:0] hw_dir = '0, ext_v = '0, ext_e = '0;
    logic [7:0]  thr_i;
    logic [4:0]  thr_e;
    int          n_fail = 0, total_checks = 0;

    pio_port_top u_pio_port_top (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .pin_in_i(pin),
        .alt_out_i(alt_out), .alt_en_i(alt_en), .hw_dir_en_i(hw_en),
        .hw_dir_i(hw_dir), .pin_out_o(p_out), .pin_oe_o(p_oe),
        .alt_in_o(alt_in), .thr_int_o(thr_i), .thr_ext_o(thr_e));
    pio_pin_model u_pio_pin_model (.pin_out_i(p_out), .pin_oe_i(p_oe),
        .ext_val_i(ext_v), .ext_en_i(ext_e), .pin_o(pin));

    // 20 MHz clock
    always #25 clk_i = ~clk_i;

    // byte address of a register in a slot
    function automatic logic [31:0] ad(input logic [3:0] s, input logic [2:0] r);
        return {23'h0, s, r, 2'b00};
    endfunction

    // one single transfer; waits on hready, no fixed latency assumed
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_i);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
        do @(posedge clk_i); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do @(posedge clk_i); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(q, e)
        `CHK(hresp, 1'b0)
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // watchdog: the whole sequence needs about 130 cycles
    initial begin
        repeat (3000) @(posedge clk_i);
        n_fail++;
        final_report;
    end

    // =====================================================
    // test sequence
    // =====================================================
    initial begin
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rd(ad(pio_pkg::SLOT_P2, pio_pkg::REG_DIR), 32'h0);
        rd(ad(pio_pkg::SLOT_P2, pio_pkg::REG_OD), 32'h0);
        rd(32'h160, 32'h0);
        `CHK(p_oe, '0)
        $display("reset test done");
        // input pin: write lands in latch, read sees pin
        ext_e[B2+:16] <= 16'hFFFF;
        ext_v[B2+:16] <= 16'hA5C3;
        wr(ad(pio_pkg::SLOT_P2, pio_pkg::REG_DATA), 32'h1234);
        rd(ad(pio_pkg::SLOT_P2, pio_pkg::REG_DATA), 32'hA5C3);
        wr(ad(pio_pkg::SLOT_P2, pio_pkg::REG_DIR), 32'h00FF);
        repeat (3) @(posedge clk_i);
        rd(ad(pio_pkg::SLOT_P2, pio_pkg::REG_DATA), 32'hA534);
        `CHK(p_out[B2+:8], 8'h34)
        // rmw: pin source for inputs, latch source for outputs
        wr(ad(pio_pkg::SLOT_P2, pio_pkg::REG_RMW), 32'h0F0F0000);
        ext_e[B2+:16] <= 16'h0000;
        wr(ad(pio_pkg::SLOT_P2, pio_pkg::REG_DIR), 32'hFFFF);
        rd(ad(pio_pkg::SLOT_P2, pio_pkg::REG_DATA), 32'hA030);
        $display("latch test done");
        // open drain drives only the zeros
        wr(ad(pio_pkg::SLOT_P2, pio_pkg::REG_OD), 32'hFFFF);
        repeat (2) @(posedge clk_i);
        `CHK(p_oe[B2+:16], 16'h5FCF)
        `CHK(p_out[B2+:16], 16'h0000)
        wr(ad(pio_pkg::SLOT_P5, pio_pkg::REG_OD), 32'hFFFF);
        rd(ad(pio_pkg::SLOT_P5, pio_pkg::REG_OD), 32'h0);
        wr(ad(pio_pkg::SLOT_P5, pio_pkg::REG_DIR), 32'hFFFF);
        repeat (2) @(posedge clk_i);
        `CHK(p_oe[B5+:16], 16'h0000)
        $display("drive test done");
        // thresholds, then direction still works with them set
        wr(32'h160, 32'hFF);
        wr(32'h164, 32'h1F);
        rd(32'h160, 32'hFF);
        rd(32'h164, 32'h1F);
        `CHK({thr_i, thr_e}, 13'h1FFF)
        wr(ad(pio_pkg::SLOT_P3, pio_pkg::REG_DIR), 32'hFFFF);
        wr(ad(pio_pkg::SLOT_P3, pio_pkg::REG_DATA), 32'hFFFF);
        rd(ad(pio_pkg::SLOT_P3, pio_pkg::REG_DATA), 32'hBFFF);
        `CHK(p_oe[B3+:16], 16'hBFFF)
        // byte halves and narrow ports, unmapped slot
        wr(ad(pio_pkg::SLOT_P0L, pio_pkg::REG_DIR), 32'h1FF);
        rd(ad(pio_pkg::SLOT_P0L, pio_pkg::REG_DIR), 32'hFF);
        rd(ad(pio_pkg::SLOT_P0H, pio_pkg::REG_DIR), 32'h0);
        wr(ad(pio_pkg::SLOT_P6, pio_pkg::REG_DIR), 32'hFFFF);
        rd(ad(pio_pkg::SLOT_P6, pio_pkg::REG_DIR), 32'hFF);
        wr(32'h1E0, 32'hFFFF);
        rd(32'h1E0, 32'h0);
        $display("map test done");
        // alternate output gated by direction and latch
        alt_en[B4+:16] <= 16'h00FF;
        alt_out[B4+:16] <= 16'h00FF;
        repeat (2) @(posedge clk_i);
        `CHK(p_oe[B4+:16], 16'h0000)
        wr(ad(pio_pkg::SLOT_P4, pio_pkg::REG_DATA), 32'h0F);
        wr(ad(pio_pkg::SLOT_P4, pio_pkg::REG_DIR), 32'hFF);
        alt_out[B4+:16] <= 16'h003C;
        repeat (2) @(posedge clk_i);
        `CHK(p_out[B4+:16], 16'h000C)
        `CHK(alt_in[B4+:16], 16'h000F)
        hw_en[B1L+:16] <= 16'h00FF;
        hw_dir[B1L+:16] <= 16'h00FF;
        alt_out[B1L+:16] <= 16'h005A;
        repeat (2) @(posedge clk_i);
        `CHK(p_oe[B1L+:16], 16'h00FF)
        `CHK(p_out[B1L+:16], 16'h005A)
        $display("alternate test done");
        final_report;
    end
endmodule
